// file: common/dop_pkg.sv
// Package for the output channel block: data word layout, routing and timing constants.
// Assumes a single 25 MHz system clock domain.
package dop_pkg;

	localparam int          DOP_WORD_W       = 16;
	localparam int          DOP_DUTY_W       = 12;
	localparam int          DOP_DUTY_LSB     = 4;
	localparam int          DOP_DUTY_MSB     = 15;
	localparam logic [15:0] DOP_WORD_RST     = 16'h0000;

	// Power-on control register and its power bits
	localparam logic [7:0]  DOP_PWR_ADDR     = 8'h31;
	localparam int          DOP_PWR_DAC_BIT  = 0;
	localparam int          DOP_PWR_OP_BIT   = 1;

	// Channel configuration word layout
	localparam int          DOP_CFG_W        = 6;
	localparam int          DOP_CFG_SRC_PWM  = 0;
	localparam int          DOP_CFG_DRV_SM   = 1;
	localparam int          DOP_CFG_PWM_EN   = 2;
	localparam int          DOP_CFG_REF_EXT  = 3;
	localparam int          DOP_CFG_SM_ALONE = 4;
	localparam int          DOP_CFG_LG_ALONE = 5;
	localparam logic [5:0]  DOP_CFG_RST      = 6'h00;

	// Duty step timing
	localparam int          DOP_CLK_HZ       = 25000000;
	localparam int          DOP_NOM_HZ       = 4000000;
	localparam int          DOP_STEP_NS      = 2000;
	localparam int          DOP_CLK_NS       = 1000000000 / DOP_CLK_HZ;
	localparam int          DOP_STEP_CYC     = (DOP_STEP_NS + DOP_CLK_NS - 1) / DOP_CLK_NS;
	localparam int          DOP_PRE_W        = 8;
	localparam logic [7:0]  DOP_PRE_LAST     = 8'(DOP_STEP_CYC - 1);
	localparam logic [11:0] DOP_CNT_LAST     = 12'hFFF;
	localparam logic [11:0] DOP_SIGN_FLIP    = 12'h800;

	typedef enum logic [2:0]
	{
		DOP_RT_OFF = 3'b001,
		DOP_RT_LG  = 3'b010,
		DOP_RT_SM  = 3'b100
	} dop_route_t;

endpackage

// file: rtl/dop_pwm.sv
// Pulse-width generator with period-boundary duty reload.
// Assumes a duty word on the same clock; counts one step per prescaler wrap.
module dop_pwm
	import dop_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic                  enable,
	input  wire logic [DOP_DUTY_W-1:0] duty_code,
	output logic                       pwm_out,
	output logic                       period_end
);

	logic [DOP_PRE_W-1:0]  pre_r;
	logic [DOP_DUTY_W-1:0] cnt_r;
	logic [DOP_DUTY_W-1:0] duty_r;
	logic                  out_r;
	wire                   step_tick;
	wire                   wrap;
	wire  [DOP_DUTY_W-1:0] cnt_nxt;
	wire  [DOP_DUTY_W-1:0] duty_nxt;
	wire  [DOP_DUTY_W-1:0] thresh;

	assign step_tick  = (pre_r == DOP_PRE_LAST);
	assign wrap       = step_tick && (cnt_r == DOP_CNT_LAST);
	assign cnt_nxt    = step_tick ? cnt_r + 12'h001 : cnt_r;
	// New period compares against the duty it loads
	assign duty_nxt   = wrap ? duty_code : duty_r;
	assign thresh     = duty_nxt ^ DOP_SIGN_FLIP;
	assign pwm_out    = out_r;
	assign period_end = wrap && enable;

	always_ff @(posedge sys_clk)
	begin
		if (rst || !enable)
		begin
			// Parked on last step so enabling starts a full first step
			pre_r  <= DOP_PRE_LAST;
			cnt_r  <= DOP_CNT_LAST;
			duty_r <= duty_code;
		end
		else
		begin
			pre_r <= step_tick ? '0 : pre_r + 8'h01;
			cnt_r <= cnt_nxt;
			if (wrap)
				duty_r <= duty_code;
		end
	end

	// Output high while counter below offset duty
	always_ff @(posedge sys_clk)
	begin
		if (rst || !enable)
			out_r <= 1'b0;
		else
			out_r <= (cnt_nxt < thresh);
	end

endmodule

// file: rtl/dop_channel.sv
// Output channel control: data word, power gating, pulse-width, DAC code and switch routing.
// Assumes CPU writes arrive as single-cycle strobes on sys_clk; analog parts sit outside.
module dop_channel
	import dop_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic                  data_wr,
	input  wire logic [DOP_WORD_W-1:0] data_wdata,
	output logic      [DOP_WORD_W-1:0] output_data_word,
	input  wire logic                  pwr_wr,
	input  wire logic [7:0]            pwr_addr,
	input  wire logic [DOP_WORD_W-1:0] pwr_wdata,
	output logic                       converter_power_bit,
	output logic                       amplifier_power_bit,
	input  wire logic                  cfg_wr,
	input  wire logic [DOP_CFG_W-1:0]  cfg_wdata,
	output logic      [DOP_CFG_W-1:0]  cfg_rdata,
	output logic      [DOP_WORD_W-1:0] dac_code,
	output logic                       dac_en,
	output logic                       dac_ref_ext,
	output logic                       dac_to_large,
	output logic                       dac_to_small,
	output logic                       large_amp_en,
	output logic                       small_amp_en,
	output logic                       large_amp_buffer,
	output logic                       small_amp_buffer,
	output logic                       amp_inverting_pin_large_oe,
	output logic                       amp_inverting_pin_small_oe,
	output logic                       pwm_level,
	output logic                       large_drive_pin_pwm,
	output logic                       small_drive_pin_pwm,
	output logic                       pwm_period_end
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [DOP_WORD_W-1:0] word_r;
	logic [DOP_CFG_W-1:0]  cfg_r;
	logic                  pwr_dac_r;
	logic                  pwr_op_r;
	wire                   pwr_hit;

	assign pwr_hit = pwr_wr && (pwr_addr == DOP_PWR_ADDR);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			word_r    <= DOP_WORD_RST;
			cfg_r     <= DOP_CFG_RST;
			pwr_dac_r <= 1'b0;
			pwr_op_r  <= 1'b0;
		end
		else
		begin
			if (data_wr)
				word_r <= data_wdata;
			if (cfg_wr)
				cfg_r <= cfg_wdata;
			if (pwr_hit)
			begin
				pwr_dac_r <= pwr_wdata[DOP_PWR_DAC_BIT];
				pwr_op_r  <= pwr_wdata[DOP_PWR_OP_BIT];
			end
		end
	end

	assign output_data_word    = word_r;
	assign cfg_rdata           = cfg_r;
	assign converter_power_bit = pwr_dac_r;
	assign amplifier_power_bit = pwr_op_r;

	// ------------------------------------------------------------
	// Source and routing decode
	// ------------------------------------------------------------
	wire        src_pwm;
	wire        drv_small;
	wire        pwm_on;
	dop_route_t route;
	wire        large_busy_pwm;
	wire        small_busy_pwm;

	assign src_pwm = cfg_r[DOP_CFG_SRC_PWM];
	assign drv_small = cfg_r[DOP_CFG_DRV_SM];
	assign pwm_on = cfg_r[DOP_CFG_PWM_EN] | src_pwm;

	// DAC path needs its power; route wins over pwm for the driver pin
	assign route = !pwr_dac_r ? DOP_RT_OFF : (drv_small ? DOP_RT_SM : DOP_RT_LG);

	assign small_busy_pwm = pwm_on && (route != DOP_RT_SM);
	assign large_busy_pwm = pwm_on && (route == DOP_RT_SM);

	// ------------------------------------------------------------
	// Amplifier and switch outputs
	// ------------------------------------------------------------
	wire lg_dac;
	wire sm_dac;

	assign lg_dac = (route == DOP_RT_LG) && pwr_op_r;
	assign sm_dac = (route == DOP_RT_SM) && pwr_op_r;

	assign dac_en       = pwr_dac_r;
	assign dac_code     = word_r;
	assign dac_ref_ext  = cfg_r[DOP_CFG_REF_EXT];
	assign dac_to_large = lg_dac;
	assign dac_to_small = sm_dac;

	assign large_amp_en = pwr_op_r && !large_busy_pwm;
	assign small_amp_en = pwr_op_r && !small_busy_pwm;

	// DAC drivers forced to buffer; free amps follow their mode bit
	assign large_amp_buffer = lg_dac || !cfg_r[DOP_CFG_LG_ALONE];
	assign small_amp_buffer = sm_dac || !cfg_r[DOP_CFG_SM_ALONE];

	// Inverting pin only reachable in stand-alone mode
	assign amp_inverting_pin_large_oe = large_amp_en && !large_amp_buffer;
	assign amp_inverting_pin_small_oe = small_amp_en && !small_amp_buffer;

	// ------------------------------------------------------------
	// Pulse-width output
	// ------------------------------------------------------------
	wire pwm_raw;

	dop_pwm u_pwm
	(
		.sys_clk    (sys_clk),
		.rst        (rst),
		.enable     (pwm_on),
		.duty_code  (word_r[DOP_DUTY_MSB:DOP_DUTY_LSB]),
		.pwm_out    (pwm_raw),
		.period_end (pwm_period_end)
	);

	assign pwm_level           = pwm_raw;
	assign small_drive_pin_pwm = small_busy_pwm;
	assign large_drive_pin_pwm = large_busy_pwm;

endmodule

// file: tb/dop_load.sv
// Load model on the two drive pins of one output channel.
// Assumes pull-down loads, so an undriven pin reads low.
module dop_load
(
	input  wire logic pwm_level,
	input  wire logic large_drive_pin_pwm,
	input  wire logic small_drive_pin_pwm,
	output logic      large_pin,
	output logic      small_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	assign large_pin = large_drive_pin_pwm & pwm_level;
	assign small_pin = small_drive_pin_pwm & pwm_level;
endmodule

// file: tb/dop_channel_sva.sv
// Port checker for the output channel.
// Assumes one clock domain with a synchronous active-high reset.
module dop_channel_sva
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        data_wr,
	input wire logic [15:0] data_wdata,
	input wire logic [15:0] output_data_word,
	input wire logic [15:0] dac_code,
	input wire logic        pwr_wr,
	input wire logic [7:0]  pwr_addr,
	input wire logic [15:0] pwr_wdata,
	input wire logic        converter_power_bit,
	input wire logic        dac_to_large,
	input wire logic        dac_to_small,
	input wire logic        large_amp_buffer,
	input wire logic        small_amp_en,
	input wire logic        pwm_level,
	input wire logic        large_drive_pin_pwm,
	input wire logic        small_drive_pin_pwm
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_pwm_rise;
		$rose(pwm_level);
	endsequence
	property p_data; data_wr |=> output_data_word == $past(data_wdata); endproperty
	a_data: assert property (p_data) else $error("data word not taken");
	property p_code; dac_code == output_data_word; endproperty
	a_code: assert property (p_code) else $error("dac code differs");
	property p_pwr_on; pwr_wr && pwr_addr == 8'h31 |=> converter_power_bit == $past(pwr_wdata[0]); endproperty
	a_pwr_on: assert property (p_pwr_on) else $error("power bit not taken");
	property p_pwr_off; pwr_wr && pwr_addr != 8'h31 |=> $stable(converter_power_bit); endproperty
	a_pwr_off: assert property (p_pwr_off) else $error("power bit moved");
	property p_gate; !converter_power_bit |-> !dac_to_large && !dac_to_small; endproperty
	a_gate: assert property (p_gate) else $error("dac routed unpowered");
	property p_excl; !(dac_to_large && large_drive_pin_pwm || dac_to_small && small_drive_pin_pwm); endproperty
	a_excl: assert property (p_excl) else $error("pin conflict");
	property p_buf; dac_to_large |-> large_amp_buffer; endproperty
	a_buf: assert property (p_buf) else $error("large amp not buffer");
	property p_sm_off; small_drive_pin_pwm |-> !small_amp_en; endproperty
	a_sm_off: assert property (p_sm_off) else $error("small amp left on");
	property p_step; s_pwm_rise |-> pwm_level[*8]; endproperty
	a_step: assert property (p_step) else $error("short pwm step");
endmodule
bind dop_channel dop_channel_sva dop_channel_sva_i (.*);

// file: tb/tb.sv
// Self-checking bench for one output channel.
// Assumes the load model on the drive pins and the bound checker.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk = 0, rst = 1, data_wr = 0, pwr_wr = 0, cfg_wr = 0;
	logic [15:0] data_wdata = '0, pwr_wdata = '0, output_data_word, dac_code;
	logic [7:0]  pwr_addr = '0;
	logic [5:0]  cfg_wdata = '0, cfg_rdata;
	logic        converter_power_bit, amplifier_power_bit, dac_en, dac_ref_ext, dac_to_large, dac_to_small;
	logic        large_amp_en, small_amp_en, large_amp_buffer, small_amp_buffer, pwm_level, pwm_period_end;
	logic        amp_inverting_pin_large_oe, amp_inverting_pin_small_oe, large_drive_pin_pwm, small_drive_pin_pwm;
	logic        large_pin, small_pin;
	int          mismatches = 0, cmp_count = 0, n;
	dop_channel dop_channel_i (.*);
	dop_load dop_load_i (.*);
	always #20 sys_clk = ~sys_clk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Kind 0 data, 1 power, 2 config
	task automatic wr(input int k, input logic [15:0] v, input logic [7:0] a = 8'h31);
		@(posedge sys_clk);
		#1;
		data_wdata = v;
		pwr_wdata = v;
		cfg_wdata = v[5:0];
		pwr_addr = a;
		{data_wr, pwr_wr, cfg_wr} = 3'b100 >> k;
		@(posedge sys_clk);
		#1;
		{data_wr, pwr_wr, cfg_wr} = '0;
	endtask
	task automatic count_high;
		n = 0;
		repeat (300)
		begin
			n += int'(small_pin === 1'b1);
			@(posedge sys_clk);
			#1;
		end
	endtask
	task automatic t_basic;
		chk({output_data_word[0], converter_power_bit, amplifier_power_bit, pwm_level, dac_en, small_amp_en}, 0);
		wr(1, 16'h0003, 8'h30);
		chk({converter_power_bit, amplifier_power_bit}, 0);
		wr(1, 16'h0003);
		chk({converter_power_bit, amplifier_power_bit, dac_en}, 3'b111);
		wr(0, 16'h8000);
		chk(dac_code, 16'h8000);
	endtask
	task automatic t_route;
		wr(2, 16'h0004);
		chk({dac_to_large, small_drive_pin_pwm, small_amp_en, large_amp_buffer}, 4'b1101);
		wr(2, 16'h0006);
		chk({dac_to_small, large_drive_pin_pwm, large_amp_en, small_amp_buffer}, 4'b1101);
		wr(2, 16'h0018);
		chk({dac_ref_ext, small_amp_en, small_amp_buffer, amp_inverting_pin_small_oe}, 4'b1101);
		wr(2, 16'h0001);
		chk(small_drive_pin_pwm, 1);
		wr(2, 16'h0000);
	endtask
	task automatic t_pwm;
		wr(0, 16'h801F);
		wr(2, 16'h0004);
		count_high();
		chk(16'(n), 16'd50);
		wr(0, 16'h7FF0);
		count_high();
		chk(16'(n), 16'd0);
	endtask
	task automatic end_of_test;
		$display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge sys_clk);
		#1;
		rst = 0;
		t_basic();
		t_route();
		t_pwm();
		end_of_test();
	end
endmodule
